// ---- src/fmt_pkg.sv ----
/*
 * Shared constants for the flash mode and timer control block: register
 * addresses, field positions, reset values, operating modes, serial link
 * phases and timing figures.
 * Assumes a 100 MHz reference clock and a two-wire serial host link.
 */
// Summary of operation
// RULE1: low supply at enable, no abort: reduce current, flag
// RULE2: low supply at enable, abort set: stay off, flag
// RULE3: fixed boost select drives outputs at constant 5V
// RULE4: host clears mode, enable, torch before fixed boost
// RULE5: fixed boost clear: behave per operating mode
// RULE6: codes 0 to 7F: 2ms steps from 2ms
// RULE7: codes 80h up: (code-127)*8+256 ms
// RULE8: mode 00: shutdown, or external torch if requested
// RULE9: mode 01: indicator, six low bits, 31.25kHz pwm
// RULE10: mode 10: assist light, seven low current bits
// RULE11: mode 11: flash, full current code
// RULE12: after flash pulse clear enable and mode
// RULE13: host writes zero to reserved control bit 2
// RULE14: enable bit 3 switches sinks, resets to 0
// RULE15: fault bit 0 shows low supply event, reset 0
// RULE16: flash starts on enable, ends at duration expiry
// RULE17: timer reloads each flash start, idle otherwise
package fmt_pkg;

    // register addresses on the serial link
    localparam logic [7:0] ADDR_SINK_CURRENT = 8'h01;
    localparam logic [7:0] ADDR_SUPPLY_CFG   = 8'h03;
    localparam logic [7:0] ADDR_DURATION     = 8'h05;
    localparam logic [7:0] ADDR_CONTROL      = 8'h06;
    localparam logic [7:0] ADDR_FAULT        = 8'h08;
    localparam logic [7:0] ADDR_AUX          = 8'h09;

    // reset values
    localparam logic [7:0] RST_SINK_CURRENT  = 8'h00;
    localparam logic [7:0] RST_SUPPLY_CFG    = 8'h2C;
    localparam logic [7:0] RST_DURATION      = 8'h23;
    localparam logic [7:0] RST_AUX           = 8'h00;

    // field positions
    localparam int CTRL_MODE_LSB   = 0;
    localparam int CTRL_OUT_ON_BIT = 3;
    localparam int SUP_RUN_LSB     = 0;
    localparam int SUP_START_LSB   = 3;
    localparam int SUP_ABORT_BIT   = 6;
    localparam int SUP_CONSTV_BIT  = 7;
    localparam int AUX_DUTY_LSB    = 0;
    localparam int AUX_TORCH_BIT   = 4;
    localparam int FAULT_UVLO_BIT  = 0;

    // operating modes
    localparam logic [1:0] MODE_SHUTDOWN  = 2'h0;
    localparam logic [1:0] MODE_INDICATOR = 2'h1;
    localparam logic [1:0] MODE_ASSIST    = 2'h2;
    localparam logic [1:0] MODE_FLASH     = 2'h3;

    // threshold code that switches the startup check off
    localparam logic [2:0] THRESH_OFF     = 3'h0;

    // serial link framing
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK  = 4'h8;

    typedef enum logic [4:0] {
        PH_ADDR   = 5'b00001,
        PH_PTR    = 5'b00010,
        PH_WDATA  = 5'b00100,
        PH_RDATA  = 5'b01000,
        PH_IGNORE = 5'b10000
    } fmt_phase_t;

    // flash duration encoding
    localparam logic [7:0]  SHORT_LAST_CODE = 8'h7F;
    localparam logic [10:0] SHORT_STEP_MS   = 11'h002;
    localparam logic [10:0] LONG_OFFSET     = 11'h07F;
    localparam logic [10:0] LONG_STEP_MS    = 11'h008;
    localparam logic [10:0] LONG_BASE_MS    = 11'h100;

    // timing
    localparam int CLK_PERIOD_NS  = 10;
    localparam int NS_PER_MS      = 1000000;
    localparam int MS_CYCLES      = NS_PER_MS / CLK_PERIOD_NS;
    localparam int PWM_PERIOD_NS  = 32000;
    localparam int PWM_DUTY_STEPS = 16;
    localparam logic [11:0] PWM_PERIOD_CYC =
        12'(PWM_PERIOD_NS / CLK_PERIOD_NS);
    localparam logic [11:0] PWM_STEP_CYC =
        12'(PWM_PERIOD_NS / CLK_PERIOD_NS / PWM_DUTY_STEPS);

endpackage

// ---- src/fmt_link.sv ----
/*
 * Serial link byte engine, clocked by the host's serial clock.
 * Assumes the reference domain holds link_clear_in high outside frames
 * and pulses it at each start; words leave by a toggle handshake.
 */
module fmt_link
    import fmt_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h2A // arbitrary value
) (
    // link clock and frame clear
    input  wire logic       scl_clk_in,
    input  wire logic       link_clear_in,
    // data pin
    input  wire logic       sda_in,
    output logic            sda_oe_n_out,
    // to and from the reference domain
    input  wire logic [7:0] read_hold_in,
    output logic            msg_tog_out,
    output logic            msg_wr_out,
    output logic            msg_rd_out,
    output logic [7:0]      msg_addr_out,
    output logic [7:0]      msg_data_out,
    output logic [7:0]      msg_ptr_out
);

    typedef struct packed {
        fmt_phase_t phase;
        logic [3:0] bit_cnt;
        logic [7:0] shift;
        logic [7:0] tx;
        logic [7:0] ptr;
        logic       ack_pend;
        logic       fresh;
        logic       msg_tog;
        logic       msg_wr;
        logic       msg_rd;
        logic [7:0] msg_addr;
        logic [7:0] msg_data;
        logic [7:0] msg_ptr;
    } fmt_link_t;

    fmt_link_t s;
    fmt_link_t next_s;
    logic [7:0] byte_in;
    logic       next_drive_low;

    always_comb begin
        next_s = s;
        byte_in = {s.shift[6:0], sda_in};
        next_s.ack_pend = 1'b0;
        next_s.bit_cnt = (s.bit_cnt == BIT_ACK) ? 4'h0 : s.bit_cnt + 4'h1;
        if (s.bit_cnt < BIT_ACK) begin
            next_s.shift = byte_in;
            next_s.tx = {s.tx[6:0], 1'b1};
        end
        if (s.bit_cnt == BIT_LAST) begin
            case (s.phase)
                PH_ADDR: begin
                    if (byte_in[7:1] == DEV_ADDR) begin
                        next_s.ack_pend = 1'b1;
                        next_s.fresh = byte_in[0];
                        next_s.phase = byte_in[0] ? PH_RDATA : PH_PTR;
                    end else begin
                        next_s.phase = PH_IGNORE;
                    end
                end
                PH_PTR: begin
                    next_s.ack_pend = 1'b1;
                    next_s.ptr = byte_in;
                    next_s.phase = PH_WDATA;
                    next_s.msg_tog = ~s.msg_tog;
                    next_s.msg_wr = 1'b0;
                    next_s.msg_rd = 1'b0;
                    next_s.msg_ptr = byte_in;
                end
                PH_WDATA: begin
                    next_s.ack_pend = 1'b1;
                    next_s.ptr = s.ptr + 8'h01;
                    next_s.msg_tog = ~s.msg_tog;
                    next_s.msg_wr = 1'b1;
                    next_s.msg_rd = 1'b0;
                    next_s.msg_addr = s.ptr;
                    next_s.msg_data = byte_in;
                    next_s.msg_ptr = s.ptr + 8'h01;
                end
                default: begin
                end
            endcase
        end
        // read byte: load after address ack or after host ack
        if (s.bit_cnt == BIT_ACK && s.phase == PH_RDATA) begin
            next_s.fresh = 1'b0;
            if (s.fresh || !sda_in) begin
                next_s.tx = read_hold_in;
                next_s.ptr = s.ptr + 8'h01;
                next_s.msg_tog = ~s.msg_tog;
                next_s.msg_wr = 1'b0;
                next_s.msg_rd = 1'b1;
                next_s.msg_addr = s.ptr;
                next_s.msg_ptr = s.ptr + 8'h01;
            end else begin
                next_s.phase = PH_IGNORE;
            end
        end
        next_drive_low = (s.bit_cnt == BIT_ACK && s.ack_pend) ||
                         (s.phase == PH_RDATA && s.bit_cnt < BIT_ACK &&
                          !s.tx[7]);
    end

    // clear is asynchronous because the link clock stops between frames
    always_ff @(posedge scl_clk_in or posedge link_clear_in) begin
        if (link_clear_in) begin
            s <= '{phase: PH_ADDR, default: '0};
        end else begin
            s <= next_s;
        end
    end

    // data pin changes only while the serial clock is low
    always_ff @(negedge scl_clk_in or posedge link_clear_in) begin
        if (link_clear_in) begin
            sda_oe_n_out <= 1'b1;
        end else begin
            sda_oe_n_out <= ~next_drive_low;
        end
    end

    assign msg_tog_out  = s.msg_tog;
    assign msg_wr_out   = s.msg_wr;
    assign msg_rd_out   = s.msg_rd;
    assign msg_addr_out = s.msg_addr;
    assign msg_data_out = s.msg_data;
    assign msg_ptr_out  = s.msg_ptr;

endmodule

// ---- src/fmt_flash_ctrl.sv ----
/*
 * Flash driver control: operating mode, sink enable, flash duration timer,
 * startup supply check and fixed boost selection, programmed by a host
 * over the two-wire serial link.
 * Assumes a 100 MHz reference clock, a free analogue comparator flag for
 * low battery and analogue current and boost stages fed by the outputs.
 */
module fmt_flash_ctrl
    import fmt_pkg::*;
#(
    parameter int         MS_CYC   = MS_CYCLES,
    parameter int         PRESC_W  = 17,
    parameter logic [6:0] DEV_ADDR = 7'h2A // arbitrary value
) (
    // clock and reset
    input  wire logic       ref_clk_in,
    input  wire logic       reset_n_in,
    // serial link
    input  wire logic       scl_clk_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_n_out,
    // analogue supply check
    input  wire logic       vin_below_in,
    output logic [2:0]      vin_start_thresh_out,
    output logic [2:0]      vin_run_thresh_out,
    // sink and boost control
    output logic            sink_enable_out,
    output logic [7:0]      sink_current_out,
    output logic            reduced_current_out,
    output logic            pwm_gate_out,
    output logic            boost_fixed_5v_out,
    output logic            torch_mode_out,
    output logic            flash_active_out,
    output logic            low_supply_fault_out
);

    typedef struct packed {
        // pin and handshake synchronisers
        logic               scl_m1;
        logic               scl_s;
        logic               sda_m1;
        logic               sda_s;
        logic               sda_prev;
        logic               busy;
        logic               link_clr;
        logic               tog_m1;
        logic               tog_s;
        logic               tog_prev;
        logic               vin_m1;
        logic               vin_s;
        // registers
        logic [7:0]         sink_current;
        logic [7:0]         supply_cfg;
        logic [7:0]         duration;
        logic [1:0]         mode;
        logic               out_on;
        logic [7:0]         aux;
        logic               fault_uvlo;
        logic [7:0]         read_hold;
        logic [7:0]         rd_ptr;
        // control state
        logic               out_on_prev;
        logic               abort;
        logic               reduced;
        logic               flash_active;
        logic [PRESC_W-1:0] presc;
        logic [10:0]        ms_left;
        logic [11:0]        pwm_cnt;
        // registered outputs
        logic               o_sink_en;
        logic [7:0]         o_current;
        logic               o_pwm;
        logic               o_torch;
    } fmt_state_t;

    localparam fmt_state_t RESET_STATE = '{
        busy:         1'b0,
        link_clr:     1'b1,
        sda_m1:       1'b1,
        sda_s:        1'b1,
        sda_prev:     1'b1,
        sink_current: RST_SINK_CURRENT,
        supply_cfg:   RST_SUPPLY_CFG,
        duration:     RST_DURATION,
        mode:         MODE_SHUTDOWN,
        aux:          RST_AUX,
        default:      '0
    };

    localparam logic [PRESC_W-1:0] PRESC_LOAD = PRESC_W'(MS_CYC - 1);

    fmt_state_t s;
    fmt_state_t next_s;

    logic       msg_tog;
    logic       msg_wr;
    logic       msg_rd;
    logic [7:0] msg_addr;
    logic [7:0] msg_data;
    logic [7:0] msg_ptr;

    logic       start_cond;
    logic       stop_cond;
    logic       msg_evt;
    logic       rise;
    logic       const_v;
    logic       low_at_start;
    logic       fault_set;
    logic       fault_clr;
    logic [3:0] duty;

    // flash length in ms for a duration code
    function automatic logic [10:0] duration_ms(input logic [7:0] code);
        logic [10:0] c;
        c = {3'h0, code};
        if (code <= SHORT_LAST_CODE) begin
            duration_ms = (c + 11'h001) * SHORT_STEP_MS;       // [RULE6]
        end else begin
            duration_ms = (c - LONG_OFFSET) * LONG_STEP_MS
                          + LONG_BASE_MS;                      // [RULE7]
        end
    endfunction

    // read view of the register map; unmapped addresses read zero
    function automatic logic [7:0] read_reg(input logic [7:0] a,
                                            input fmt_state_t st);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            ADDR_SINK_CURRENT: v = st.sink_current;
            ADDR_SUPPLY_CFG:   v = st.supply_cfg;
            ADDR_DURATION:     v = st.duration;
            ADDR_CONTROL: begin
                v[CTRL_MODE_LSB +: 2] = st.mode;
                v[CTRL_OUT_ON_BIT]    = st.out_on;
            end
            ADDR_FAULT:        v[FAULT_UVLO_BIT] = st.fault_uvlo; // [RULE15]
            ADDR_AUX:          v = st.aux;
            default:           v = 8'h00;
        endcase
        read_reg = v;
    endfunction

    fmt_link #(
        .DEV_ADDR (DEV_ADDR)
    ) u_link (
        .scl_clk_in    (scl_clk_in),
        .link_clear_in (s.link_clr),
        .sda_in        (sda_in),
        .sda_oe_n_out  (sda_oe_n_out),
        .read_hold_in  (s.read_hold),
        .msg_tog_out   (msg_tog),
        .msg_wr_out    (msg_wr),
        .msg_rd_out    (msg_rd),
        .msg_addr_out  (msg_addr),
        .msg_data_out  (msg_data),
        .msg_ptr_out   (msg_ptr)
    );

    always_comb begin
        next_s = s;

        // pins and handshake toggle pass two flops first
        next_s.scl_m1 = scl_clk_in;
        next_s.scl_s = s.scl_m1;
        next_s.sda_m1 = sda_in;
        next_s.sda_s = s.sda_m1;
        next_s.sda_prev = s.sda_s;
        next_s.tog_m1 = msg_tog;
        next_s.tog_s = s.tog_m1;
        next_s.tog_prev = s.tog_s;
        next_s.vin_m1 = vin_below_in;
        next_s.vin_s = s.vin_m1;

        // start and stop framing; a repeated start clears the engine too
        start_cond = s.scl_s && s.sda_prev && !s.sda_s;
        stop_cond = s.scl_s && !s.sda_prev && s.sda_s;
        if (start_cond) begin
            next_s.busy = 1'b1;
        end else if (stop_cond) begin
            next_s.busy = 1'b0;
        end
        next_s.link_clr = start_cond || !next_s.busy;

        // a toggle from the frame clear after a stop is no message
        msg_evt = (s.tog_s ^ s.tog_prev) && !s.link_clr;

        const_v = s.supply_cfg[SUP_CONSTV_BIT];
        duty = s.aux[AUX_DUTY_LSB +: 4];
        rise = s.out_on && !s.out_on_prev;
        next_s.out_on_prev = s.out_on;
        fault_set = 1'b0;

        // flash duration timer
        if (s.flash_active) begin
            if (s.mode != MODE_FLASH || !s.out_on || const_v) begin
                next_s.flash_active = 1'b0;                    // [RULE17]
            end else if (s.presc == '0) begin
                next_s.presc = PRESC_LOAD;
                next_s.ms_left = s.ms_left - 11'h001;
                if (s.ms_left == 11'h001) begin
                    next_s.flash_active = 1'b0;                // [RULE16]
                    next_s.out_on = 1'b0;                      // [RULE12]
                    next_s.mode = MODE_SHUTDOWN;               // [RULE12]
                end
            end else begin
                next_s.presc = s.presc - PRESC_W'(1);
            end
        end else begin
            next_s.presc = PRESC_LOAD;                         // [RULE17]
            next_s.ms_left = 11'h000;
        end

        // startup supply check on the enable rising edge
        low_at_start = s.vin_s &&
            s.supply_cfg[SUP_START_LSB +: 3] != THRESH_OFF;
        if (rise && s.mode == MODE_FLASH && !const_v) begin
            if (low_at_start) begin
                fault_set = 1'b1;
                if (s.supply_cfg[SUP_ABORT_BIT]) begin
                    next_s.abort = 1'b1;                       // [RULE2]
                end else begin
                    next_s.reduced = 1'b1;                     // [RULE1]
                end
            end
            if (!(low_at_start && s.supply_cfg[SUP_ABORT_BIT])) begin
                next_s.flash_active = 1'b1;                    // [RULE16]
                next_s.ms_left = duration_ms(s.duration);      // [RULE17]
                next_s.presc = PRESC_LOAD;
            end
        end
        if (!s.out_on) begin
            next_s.abort = 1'b0;
            next_s.reduced = 1'b0;
        end

        // host writes win over the automatic clear in the same cycle
        if (msg_evt && msg_wr) begin
            case (msg_addr)
                ADDR_SINK_CURRENT: next_s.sink_current = msg_data;
                ADDR_SUPPLY_CFG:   next_s.supply_cfg = msg_data;
                ADDR_DURATION:     next_s.duration = msg_data;
                ADDR_CONTROL: begin
                    // bit 2 is not stored; host keeps it at zero [RULE13]
                    next_s.mode = msg_data[CTRL_MODE_LSB +: 2];
                    next_s.out_on = msg_data[CTRL_OUT_ON_BIT];
                end
                ADDR_AUX:          next_s.aux = msg_data;
                default: begin
                end
            endcase
        end

        // fault flag clears on read; a new event in that cycle wins
        fault_clr = msg_evt && msg_rd && s.rd_ptr == ADDR_FAULT;
        if (fault_set) begin
            next_s.fault_uvlo = 1'b1;                          // [RULE15]
        end else if (fault_clr) begin
            next_s.fault_uvlo = 1'b0;
        end

        if (msg_evt) begin
            next_s.rd_ptr = msg_rd ? s.rd_ptr + 8'h01 : msg_ptr;
            next_s.read_hold = read_reg(next_s.rd_ptr, s);
        end

        // indicator pwm, free running
        if (s.pwm_cnt == PWM_PERIOD_CYC - 12'h001) begin
            next_s.pwm_cnt = 12'h000;
        end else begin
            next_s.pwm_cnt = s.pwm_cnt + 12'h001;
        end

        // sink drive per mode
        next_s.o_sink_en = 1'b0;
        next_s.o_current = 8'h00;
        next_s.o_pwm = 1'b0;
        next_s.o_torch = 1'b0;
        if (!const_v) begin                                    // [RULE5]
            case (s.mode)
                MODE_SHUTDOWN: begin
                    next_s.o_torch = s.aux[AUX_TORCH_BIT];     // [RULE8]
                end
                MODE_INDICATOR: begin
                    next_s.o_sink_en = s.out_on;               // [RULE14]
                    next_s.o_current = {2'h0, s.sink_current[5:0]}; // [RULE9]
                    next_s.o_pwm = s.pwm_cnt <
                        ({8'h00, duty} + 12'h001) * PWM_STEP_CYC; // [RULE9]
                end
                MODE_ASSIST: begin
                    next_s.o_sink_en = s.out_on;               // [RULE14]
                    next_s.o_current = {1'b0, s.sink_current[6:0]}; // [RULE10]
                    next_s.o_pwm = 1'b1;
                end
                MODE_FLASH: begin
                    // sinks stay off after an abort [RULE2]
                    next_s.o_sink_en = s.out_on && s.flash_active &&
                                       !s.abort;               // [RULE14]
                    next_s.o_current = s.sink_current;         // [RULE11]
                    next_s.o_pwm = 1'b1;
                end
                default: begin
                end
            endcase
        end
        if (!next_s.o_sink_en) begin
            next_s.o_current = 8'h00;
            next_s.o_pwm = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            s <= RESET_STATE;
        end else begin
            s <= next_s;
        end
    end

    // open drain: only ever pulls low
    assign sda_out              = 1'b0;
    assign vin_start_thresh_out = s.supply_cfg[SUP_START_LSB +: 3];
    assign vin_run_thresh_out   = s.supply_cfg[SUP_RUN_LSB +: 3];
    assign sink_enable_out      = s.o_sink_en;
    assign sink_current_out     = s.o_current;
    assign reduced_current_out  = s.reduced;                   // [RULE1]
    assign pwm_gate_out         = s.o_pwm;
    assign boost_fixed_5v_out   = s.supply_cfg[SUP_CONSTV_BIT]; // [RULE3]
    assign torch_mode_out       = s.o_torch;
    assign flash_active_out     = s.flash_active;
    assign low_supply_fault_out = s.fault_uvlo;

endmodule

// ---- sim/fmt_flash_ctrl_properties.sv ----
/*
 * Port checks for the flash control block.
 * Assumes a bind with MS_CYC passed on.
 */
module fmt_flash_ctrl_properties
    import fmt_pkg::*;
#(
    parameter int MS_CYC = MS_CYCLES
) (
    // clock and reset
    input wire logic       ref_clk_in,
    input wire logic       reset_n_in,
    // watched outputs
    input wire logic       sink_enable_out,
    input wire logic [7:0] sink_current_out,
    input wire logic       reduced_current_out,
    input wire logic       boost_fixed_5v_out,
    input wire logic       torch_mode_out,
    input wire logic       flash_active_out,
    input wire logic       low_supply_fault_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);
    int flash_cyc;
    always_ff @(posedge ref_clk_in)
        flash_cyc <= flash_active_out ? flash_cyc + 1 : 0;
    five_v_off_a: assert property (
        boost_fixed_5v_out [*3] |-> !sink_enable_out) else $error("on in 5V");
    sink_zero_a: assert property (
        !sink_enable_out |-> sink_current_out == 8'h00) else $error("cur off");
    flash_on_a: assert property (
        $rose(flash_active_out) |=> sink_enable_out) else $error("no start");
    flash_clear_a: assert property (
        $fell(flash_active_out) |=> !sink_enable_out) else $error("no clear");
    flash_max_a: assert property (
        flash_active_out |-> flash_cyc < 1280 * MS_CYC) else $error("long");
    reduced_flag_a: assert property (
        $rose(reduced_current_out) |-> ##[0:2] low_supply_fault_out)
        else $error("no fault flag");
    torch_excl_a: assert property (
        torch_mode_out |-> !flash_active_out) else $error("torch in flash");
    sink_5v_a: assert property (
        $rose(sink_enable_out) |-> !boost_fixed_5v_out) else $error("5V on");
    cover property ($rose(flash_active_out));
    cover property ($rose(reduced_current_out));
    cover property ($rose(torch_mode_out));
endmodule

bind fmt_flash_ctrl fmt_flash_ctrl_properties #(.MS_CYC(MS_CYC))
    u_props (.*);

// ---- sim/fmt_host_model.sv ----
/*
 * Behavioural two-wire host: register write and read frames.
 * Assumes a pulled-up data wire; clock idles high.
 */
module fmt_host_model #(
    parameter logic [6:0] DEV_ADDR = 7'h2A // arbitrary value
) (
    // link pins
    output logic      scl_out,
    output logic      sda_out,
    input  wire logic sda_in
);
    timeunit 1ns;
    timeprecision 100ps;
    // slow bits let the read prefetch settle
    localparam int HP = 75;
    initial {scl_out, sda_out} = 2'b11;
    task automatic bit_io(input logic b, output logic r);
        #20 sda_out = b;
        #55 scl_out = 1'b1;
        r = sda_in;
        #HP scl_out = 1'b0;
    endtask
    // ack slot released: nack ends a read
    task automatic byte_io(input logic [7:0] t, output logic [7:0] r);
        logic a;
        for (int i = 7; i >= 0; i--)
            bit_io(t[i], r[i]);
        bit_io(1'b1, a);
    endtask
    task automatic start();
        #HP sda_out = 1'b0;
        #HP scl_out = 1'b0;
    endtask
    task automatic stop();
        #20 sda_out = 1'b0;
        #55 scl_out = 1'b1;
        #HP sda_out = 1'b1;
        #HP;
    endtask
    task automatic xfer(input logic [7:0] a, d, input logic w,
                        output logic [7:0] q);
        start();
        byte_io({DEV_ADDR, 1'b0}, q);
        byte_io(a, q);
        if (w)
            byte_io(d, q);
        stop();
        if (!w) begin
            start();
            byte_io({DEV_ADDR, 1'b1}, q);
            byte_io(8'hFF, q);
            stop();
        end
    endtask
endmodule

// ---- sim/fmt_flash_ctrl_tb_top.sv ----
/*
 * Self-checking bench: flash timing, mode currents, supply check, boost.
 * Assumes the host model and bound checker.
 */
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
    n_errors++; $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module fmt_flash_ctrl_tb_top
    import fmt_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int MS = 20;
    logic        ref_clk_in = 1'b0;
    logic        reset_n_in = 1'b0;
    logic        vin_below_in = 1'b0;
    logic        scl, sda_h, sda_oe_n, sink_en, flash_act, red, fault;
    logic        fix5, torch, seen_red;
    logic [7:0]  cur, d, k, seen_cur;
    logic [7:0]  codes [4] = '{8'h00, 8'h7F, 8'h80, 8'h00};
    logic [31:0] seed = 32'hFDC1FB74;
    int          n_errors = 0;
    int          cmp_count = 0;
    int          n;
    wire         sda = sda_h & sda_oe_n;
    fmt_flash_ctrl #(.MS_CYC(MS)) uut (
        .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
        .scl_clk_in(scl), .sda_in(sda), .sda_out(), .sda_oe_n_out(sda_oe_n),
        .vin_below_in(vin_below_in), .vin_start_thresh_out(),
        .vin_run_thresh_out(), .sink_enable_out(sink_en),
        .sink_current_out(cur), .reduced_current_out(red), .pwm_gate_out(),
        .boost_fixed_5v_out(fix5), .torch_mode_out(torch),
        .flash_active_out(flash_act), .low_supply_fault_out(fault));
    fmt_host_model host (.scl_out(scl), .sda_out(sda_h), .sda_in(sda));
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    function automatic int dur(input logic [7:0] c);
        return c <= 8'h7F ? (c + 1) * 2 : (c - 127) * 8 + 256;
    endfunction
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, v);
        host.xfer(a, v, 1'b1, d);
        repeat (8) @(negedge ref_clk_in);
    endtask
    task automatic rdchk(input logic [7:0] a, e);
        host.xfer(a, 8'h00, 1'b0, d);
        `CHK("register", e, d)
    endtask
    // pulse may end mid-frame
    task automatic flash(input logic [7:0] code);
        wr(ADDR_DURATION, code);
        n = 0;
        fork
            wr(ADDR_CONTROL, 8'h0B);
            begin
                @(negedge ref_clk_in iff flash_act === 1'b1);
                while (flash_act === 1'b1) begin
                    @(negedge ref_clk_in);
                    n++;
                    if (n == 3)
                        {seen_cur, seen_red} = {cur, red};
                end
            end
        join
        `CHK("flash_cycles", dur(code) * MS, n)
        rdchk(ADDR_CONTROL, 8'h00);
    endtask
    initial forever #5 ref_clk_in = ~ref_clk_in;
    initial begin
        #1_000_000;
        n_errors++;
        $display("watchdog expired");
        tally_and_finish();
    end
    initial begin
        repeat (6) @(negedge ref_clk_in);
        reset_n_in = 1'b1;
        repeat (4) @(negedge ref_clk_in);
        `CHK("sink_en", 1'b0, sink_en)
        `CHK("fault", 1'b0, fault)
        rdchk(ADDR_DURATION, RST_DURATION);
        rdchk(ADDR_SUPPLY_CFG, RST_SUPPLY_CFG);
        rdchk(8'h02, 8'h00);
        $display("test reset done");
        codes[3] = rnd();
        foreach (codes[i]) begin
            k = rnd();
            wr(ADDR_SINK_CURRENT, k);
            flash(codes[i]);
            `CHK("flash_cur", k, seen_cur)
        end
        $display("test durations done");
        @(negedge ref_clk_in) vin_below_in = 1'b1;
        flash(8'h00);
        `CHK("reduced", 1'b1, seen_red)
        rdchk(ADDR_FAULT, 8'h01);
        rdchk(ADDR_FAULT, 8'h00);
        wr(ADDR_SUPPLY_CFG, RST_SUPPLY_CFG | 8'h40);
        wr(ADDR_CONTROL, 8'h0B);
        repeat (100) @(negedge ref_clk_in);
        `CHK("abort_sink", 1'b0, sink_en)
        `CHK("abort_fault", 1'b1, fault)
        wr(ADDR_CONTROL, 8'h00);
        vin_below_in = 1'b0;
        wr(ADDR_SUPPLY_CFG, 8'hAC);
        `CHK("fixed_5v", 1'b1, fix5)
        wr(ADDR_SUPPLY_CFG, RST_SUPPLY_CFG);
        wr(ADDR_CONTROL, 8'h0A);
        `CHK("assist_cur", k & 8'h7F, cur)
        wr(ADDR_CONTROL, 8'h09);
        `CHK("indicator_cur", k & 8'h3F, cur)
        wr(ADDR_CONTROL, 8'h00);
        `CHK("sink_off", 1'b0, sink_en)
        wr(ADDR_AUX, 8'h10);
        `CHK("torch", 1'b1, torch)
        $display("test modes done");
        tally_and_finish();
    end
endmodule
